/* hdl/cpts_top.sv */
// Purpose: Processor priority level, nesting lock and trap status flags
// Assumes: Trap pulses and core loads come from logic on CLK_SYS
// Notes: Core level load wins over a software write in the same cycle
//
// Functional notes
// R1 - Level field sits at status word bits 7..5, values 0 to 7.
// R2 - Field value seven blocks every user interrupt request.
// R3 - High bit above the field gives the effective 4-bit level.
// R4 - Nesting disable set makes the level field ignore software writes.
// R5 - High bit sits at core control bit 3; one means above seven.
// R6 - Software may read and clear the high bit, never set it; resets 0.
// R7 - Nesting disable is read/write at interrupt control bit 15.
// R8 - Arithmetic trap flag at bit 4 sets on an overflow trap.
// R9 - Address trap flag at bit 3 sets on an address error trap.
// R10 - Stack trap flag at bit 2 sets on a stack error trap.
// R11 - Oscillator trap flag at bit 1 sets on oscillator failure.
// R12 - Interrupt control bits 14..5 and bit 0 read as zero.
// R13 - Software can never set the high bit, so traps stay unmaskable.
// R14 - Software may change the level by writing the field when allowed.
// R15 - Trap flags stay set until written to zero; reset clears them.
`timescale 1ns/10ps
module cpts_top
   import cpts_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   input wire logic ARITH_TRAP,
   input wire logic ADDR_TRAP,
   input wire logic STACK_TRAP,
   input wire logic OSC_FAIL_TRAP,
   input wire logic CORE_LVL_LOAD,
   input wire logic [3:0] CORE_LVL,
   input wire logic USER_REQ,
   input wire logic [2:0] USER_REQ_LVL,
   output logic USER_GRANT,
   output logic [3:0] PRIORITY_LEVEL,
   output logic NESTING_DISABLE,
   output logic [3:0] TRAP_FLAGS,
   output logic IRQ
);

   function automatic logic hit(input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] reg_idx);
      hit = (a == reg_idx);
   endfunction

   logic [2:0] cpu_priority_level;
   logic [2:0] next_cpu_priority_level;
   logic priority_level_high_bit;
   logic next_priority_level_high_bit;
   logic nesting_disable;
   logic next_nesting_disable;
   cpts_trap_t trap_flags;
   cpts_trap_t next_trap_flags;
   cpts_trap_t trap_event;
   cpts_trap_t next_trap_event;
   cpts_trap_t trap_mask;
   cpts_trap_t next_trap_mask;
   logic irq;
   logic next_irq;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;
   cpts_trap_t trap_in;
   logic wr_status;
   logic wr_core;
   logic wr_ctrl;

   assign trap_in = {ARITH_TRAP, ADDR_TRAP, STACK_TRAP, OSC_FAIL_TRAP};
   assign wr_status = WR && hit(ADDR, ADR_CPU_STATUS);
   assign wr_core = WR && hit(ADDR, ADR_CORE_CTRL);
   assign wr_ctrl = WR && hit(ADDR, ADR_INT_CTRL);

   // Priority level group
   always_comb begin
      next_cpu_priority_level = cpu_priority_level;
      next_priority_level_high_bit = priority_level_high_bit;
      if (CORE_LVL_LOAD) begin
         // R3 core loads full level
         next_cpu_priority_level = CORE_LVL[2:0];
         next_priority_level_high_bit = CORE_LVL[3];
      end else begin
         // R4 lock while nesting off
         // R14 software level change
         if (wr_status && !nesting_disable) begin
            next_cpu_priority_level = WDATA[SW_LVL_MSB:SW_LVL_LSB];
         end
         // R6 clear only, never set
         // R13 no software set
         if (wr_core && !WDATA[CC_HIGH_BIT]) begin
            next_priority_level_high_bit = 1'b0;
         end
      end
   end

   // R1 level field storage
   // R5 high bit storage
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         cpu_priority_level <= LVL_RST;
         priority_level_high_bit <= HIGH_RST;
      end else begin
         cpu_priority_level <= next_cpu_priority_level;
         priority_level_high_bit <= next_priority_level_high_bit;
      end
   end

   // Control and trap flag group
   always_comb begin
      next_nesting_disable = nesting_disable;
      // R8 R9 R10 R11 traps set flags
      // R15 sticky trap flags
      next_trap_flags = trap_flags | trap_in;
      if (wr_ctrl) begin
         // R7 nesting disable write
         next_nesting_disable = WDATA[IC_NEST_BIT];
         // A trap in the clearing cycle still lands
         next_trap_flags = WDATA[IC_TRAP_MSB:IC_TRAP_LSB] | trap_in;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         nesting_disable <= NEST_RST;
         trap_flags <= TRAP_RST;
      end else begin
         nesting_disable <= next_nesting_disable;
         trap_flags <= next_trap_flags;
      end
   end

   // Interrupt group: write-one-to-clear events, mask, level output
   always_comb begin
      next_trap_event = trap_event | trap_in;
      next_trap_mask = trap_mask;
      if (WR && hit(ADDR, ADR_TRAP_EVENT)) begin
         next_trap_event = (trap_event & ~WDATA[EV_MSB:EV_LSB]) | trap_in;
      end
      if (WR && hit(ADDR, ADR_TRAP_MASK)) begin
         next_trap_mask = WDATA[EV_MSB:EV_LSB];
      end
      next_irq = |(next_trap_event & next_trap_mask);
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         trap_event <= TRAP_RST;
         trap_mask <= TRAP_RST;
         irq <= 1'b0;
      end else begin
         trap_event <= next_trap_event;
         trap_mask <= next_trap_mask;
         irq <= next_irq;
      end
   end

   // Read group; data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = RDATA_RST;
      if (RD) begin
         if (hit(ADDR, ADR_CPU_STATUS)) begin
            // R1 level readback
            next_rdata[SW_LVL_MSB:SW_LVL_LSB] = cpu_priority_level;
         end else if (hit(ADDR, ADR_CORE_CTRL)) begin
            // R5 high bit readback
            next_rdata[CC_HIGH_BIT] = priority_level_high_bit;
         end else if (hit(ADDR, ADR_INT_CTRL)) begin
            // R12 unimplemented bits zero
            next_rdata[IC_NEST_BIT] = nesting_disable;
            next_rdata[IC_TRAP_MSB:IC_TRAP_LSB] = trap_flags;
         end else if (hit(ADDR, ADR_TRAP_EVENT)) begin
            next_rdata[EV_MSB:EV_LSB] = trap_event;
         end else if (hit(ADDR, ADR_TRAP_MASK)) begin
            next_rdata[EV_MSB:EV_LSB] = trap_mask;
         end else begin
            next_rdata = RDATA_RST;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         rdata <= RDATA_RST;
      end else begin
         rdata <= next_rdata;
      end
   end

   cpts_pri_if pif ();

   assign pif.eff_level = {priority_level_high_bit, cpu_priority_level};
   assign pif.req = USER_REQ;
   assign pif.req_level = USER_REQ_LVL;

   cpts_pri_cmp u_cmp (
      .pif (pif.cmp)
   );

   assign USER_GRANT = pif.grant;
   assign RDATA = rdata;
   assign PRIORITY_LEVEL = {priority_level_high_bit, cpu_priority_level};
   assign NESTING_DISABLE = nesting_disable;
   assign TRAP_FLAGS = trap_flags;
   assign IRQ = irq;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   AST_LVL_FIELD: assert property ( // R1
      (RD && hit(ADDR, ADR_CPU_STATUS)) |=>
      (RDATA[SW_LVL_MSB:SW_LVL_LSB] == $past(cpu_priority_level)) &&
      (RDATA[15:8] == 8'h00) && (RDATA[4:0] == 5'h00))
      else $error("level field readback wrong");

   AST_BLOCK7: assert property ( // R2
      (cpu_priority_level == LVL_BLOCK_ALL) |-> !USER_GRANT)
      else $error("grant issued at level seven");

   AST_CORE_LOAD: assert property ( // R3
      CORE_LVL_LOAD |=> (PRIORITY_LEVEL == $past(CORE_LVL)))
      else $error("effective level not loaded by core");

   AST_NEST_LOCK: assert property ( // R4
      (wr_status && nesting_disable && !CORE_LVL_LOAD) |=>
      $stable(cpu_priority_level))
      else $error("level field written while locked");

   AST_SW_LEVEL: assert property ( // R14
      (wr_status && !nesting_disable && !CORE_LVL_LOAD) |=>
      (cpu_priority_level == $past(WDATA[SW_LVL_MSB:SW_LVL_LSB])))
      else $error("software level write lost");

   AST_HIGH_READ: assert property ( // R5
      (RD && hit(ADDR, ADR_CORE_CTRL)) |=>
      (RDATA == ($past(priority_level_high_bit) ? 16'h0008 : 16'h0000)))
      else $error("high bit readback wrong");

   AST_HIGH_NOSET: assert property ( // R6
      (!CORE_LVL_LOAD && !priority_level_high_bit) |=>
      !priority_level_high_bit)
      else $error("high bit set without core load");

   AST_HIGH_CLEAR: assert property ( // R13
      (wr_core && !CORE_LVL_LOAD && !WDATA[CC_HIGH_BIT]) |=>
      !priority_level_high_bit)
      else $error("high bit not cleared by write");

   AST_NEST_WRITE: assert property ( // R7
      wr_ctrl |=> (NESTING_DISABLE == $past(WDATA[IC_NEST_BIT])))
      else $error("nesting disable write lost");

   AST_ARITH_SET: assert property ( // R8
      ARITH_TRAP |=> trap_flags[3])
      else $error("arith trap flag not set");

   AST_ADDR_SET: assert property ( // R9
      ADDR_TRAP |=> trap_flags[2])
      else $error("address trap flag not set");

   AST_STACK_SET: assert property ( // R10
      STACK_TRAP |=> trap_flags[1])
      else $error("stack trap flag not set");

   AST_OSC_SET: assert property ( // R11
      OSC_FAIL_TRAP |=> trap_flags[0])
      else $error("oscillator trap flag not set");

   AST_CTRL_ZERO: assert property ( // R12
      (RD && hit(ADDR, ADR_INT_CTRL)) |=>
      (RDATA[14:5] == 10'h000) && !RDATA[0] &&
      (RDATA[4:1] == $past(trap_flags)))
      else $error("interrupt control readback wrong");

   AST_STICKY: assert property ( // R15
      (|trap_flags && !wr_ctrl) |=> ((trap_flags & $past(trap_flags)) ==
      $past(trap_flags)))
      else $error("trap flag dropped without write");

   AST_IRQ_RAISE: assert property ( // R8
      (ARITH_TRAP && trap_mask[3] && !(WR && hit(ADDR, ADR_TRAP_MASK))) |=>
      IRQ [*2] or (IRQ ##1 !IRQ))
      else $error("interrupt not raised by unmasked trap");

   AST_SET_WINS: assert property ( // R15
      (wr_ctrl && (|trap_in)) |=>
      ((trap_flags & $past(trap_in)) == $past(trap_in)))
      else $error("trap lost against a flag write");

   AST_EVENT_SET: assert property ( // R8
      (|trap_in) |=> ((trap_event & $past(trap_in)) == $past(trap_in)))
      else $error("trap event bit not set");

   AST_EVENT_CLEAR: assert property ( // R15
      (WR && hit(ADDR, ADR_TRAP_EVENT) && !(|trap_in)) |=>
      (trap_event == ($past(trap_event) & ~$past(WDATA[EV_MSB:EV_LSB]))))
      else $error("trap event write-one-to-clear wrong");

   AST_MASK_WRITE: assert property ( // R8
      (WR && hit(ADDR, ADR_TRAP_MASK)) |=>
      (trap_mask == $past(WDATA[EV_MSB:EV_LSB])))
      else $error("trap mask write lost");

   AST_IRQ_LEVEL: assert property ( // R8
      IRQ == |(trap_event & trap_mask))
      else $error("interrupt output out of step");

   AST_RDATA_IDLE: assert property ( // R12
      !RD |=> (RDATA == RDATA_RST))
      else $error("read data stands without a read");

   AST_UNMAPPED: assert property ( // R12
      (RD && (ADDR > ADR_TRAP_MASK)) |=> (RDATA == RDATA_RST))
      else $error("unmapped index read not zero");

   AST_NEST_HOLD: assert property ( // R7
      !wr_ctrl |=> $stable(nesting_disable))
      else $error("nesting disable moved without write");

   AST_LVL_HOLD: assert property ( // R1
      (!wr_status && !CORE_LVL_LOAD) |=> $stable(cpu_priority_level))
      else $error("level field moved without write");

   AST_HIGH_HOLD: assert property ( // R6
      (!wr_core && !CORE_LVL_LOAD) |=> $stable(priority_level_high_bit))
      else $error("high bit moved without write");

   AST_GRANT_ABOVE: assert property ( // R3
      (USER_REQ && !priority_level_high_bit &&
      (cpu_priority_level != LVL_BLOCK_ALL) &&
      ({1'b0, USER_REQ_LVL} > PRIORITY_LEVEL)) |-> USER_GRANT)
      else $error("grant withheld above current level");

   AST_GRANT_HIGH: assert property ( // R3
      priority_level_high_bit |-> !USER_GRANT)
      else $error("grant issued at level eight or more");

   AST_GRANT_NOREQ: assert property ( // R2
      !USER_REQ |-> !USER_GRANT)
      else $error("grant issued with no request");

endmodule

/* hdl/cpts_pkg.sv */
// Purpose: Shared constants for the priority level and trap status block
// Assumes: One core clock, registers addressed by a 3-bit word index
// Notes: Trap vector order is arith, address, stack, oscillator (msb first)
package cpts_pkg;

   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 3;

   // Register indices on the plain register port
   localparam logic [2:0] ADR_CPU_STATUS = 3'h0;
   localparam logic [2:0] ADR_CORE_CTRL = 3'h1;
   localparam logic [2:0] ADR_INT_CTRL = 3'h2;
   localparam logic [2:0] ADR_TRAP_EVENT = 3'h3;
   localparam logic [2:0] ADR_TRAP_MASK = 3'h4;

   // Field positions
   localparam int unsigned SW_LVL_LSB = 5;
   localparam int unsigned SW_LVL_MSB = 7;
   localparam int unsigned CC_HIGH_BIT = 3;
   localparam int unsigned IC_NEST_BIT = 15;
   localparam int unsigned IC_TRAP_LSB = 1;
   localparam int unsigned IC_TRAP_MSB = 4;
   localparam int unsigned EV_LSB = 0;
   localparam int unsigned EV_MSB = 3;

   // Reset values
   localparam logic [2:0] LVL_RST = 3'h0;
   localparam logic HIGH_RST = 1'b0;
   localparam logic NEST_RST = 1'b0;
   localparam logic [3:0] TRAP_RST = 4'h0;
   localparam logic [15:0] RDATA_RST = 16'h0000;

   // Field level that shuts out every user request
   localparam logic [2:0] LVL_BLOCK_ALL = 3'h7;

   typedef logic [3:0] cpts_trap_t;
   typedef logic [3:0] cpts_level_t;

endpackage

/* hdl/cpts_pri_if.sv */
// Purpose: Carries the effective level and a user request to the comparator
// Assumes: Purely combinational path within one clock domain
// Notes: Grant is a same-cycle answer
`timescale 1ns/10ps
interface cpts_pri_if;
   logic [3:0] eff_level;
   logic req;
   logic [2:0] req_level;
   logic grant;
   modport ctl (output eff_level, output req, output req_level,
      input grant);
   modport cmp (input eff_level, input req, input req_level,
      output grant);
endinterface

/* hdl/cpts_pri_cmp.sv */
// Purpose: Decides whether a user request may preempt the running code
// Assumes: Request levels span 0 to 7 only
// Notes: Combinational; the owner registers nothing here
`timescale 1ns/10ps
module cpts_pri_cmp
   import cpts_pkg::*;
(
   cpts_pri_if.cmp pif
);

   function automatic logic above(input logic [2:0] req_lvl,
      input cpts_level_t eff);
      above = ({1'b0, req_lvl} > eff);
   endfunction

   // R2 level seven blocks
   // R3 four-bit compare
   // Explicit block term keeps level seven shut even if compare changes
   assign pif.grant = pif.req && (pif.eff_level[2:0] != LVL_BLOCK_ALL) &&
      above(pif.req_level, pif.eff_level);

endmodule

/* verif/cpts_core_model.sv */
// Purpose: Stand-in for the core pipeline and its trap sources
// Assumes: Everything changes just after a CLK_SYS rising edge
// Notes: Pulses last exactly one cycle, as the core's own logic does
`timescale 1ns/10ps
module cpts_core_model (
   input wire logic clk,
   output logic [3:0] trap,
   output logic lvl_load,
   output logic [3:0] lvl
);
   initial begin
      trap = 4'h0;
      lvl_load = 1'b0;
      lvl = 4'h0;
   end
   // Trap order is arith, address, stack, oscillator
   task automatic fire(input logic [3:0] t);
      @(posedge clk);
      trap <= t;
      @(posedge clk);
      trap <= 4'h0;
   endtask
   // Level bus is scrambled once released so a stale value cannot pass
   task automatic load(input logic [3:0] v);
      @(posedge clk);
      lvl_load <= 1'b1;
      lvl <= v;
      @(posedge clk);
      lvl_load <= 1'b0;
      lvl <= ~v;
   endtask
endmodule

/* verif/cpts_top_tb.sv */
// Purpose: Register, level, grant and trap checks for the whole block
// Assumes: Register port reads answer one cycle after the strobe
// Notes: Core and trap sources come from the core model
`timescale 1ns/10ps
module cpts_top_tb
   import cpts_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic req = 1'b0;
   logic [2:0] req_lvl = 3'h0;
   logic [15:0] rdata;
   logic [15:0] rv;
   logic [3:0] trap;
   logic [3:0] lvl;
   logic [3:0] prio;
   logic [3:0] flags;
   logic lvl_load;
   logic grant;
   logic nest;
   logic irq;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   cpts_core_model core (.clk(clk), .trap(trap), .lvl_load(lvl_load),
      .lvl(lvl));
   cpts_top dut (.CLK_SYS(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .ARITH_TRAP(trap[3]),
      .ADDR_TRAP(trap[2]), .STACK_TRAP(trap[1]), .OSC_FAIL_TRAP(trap[0]),
      .CORE_LVL_LOAD(lvl_load), .CORE_LVL(lvl), .USER_REQ(req),
      .USER_REQ_LVL(req_lvl), .USER_GRANT(grant), .PRIORITY_LEVEL(prio),
      .NESTING_DISABLE(nest), .TRAP_FLAGS(flags), .IRQ(irq));
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
      #1;
   endtask
   task automatic rreg(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic gchk(input logic [2:0] l, input logic e);
      @(posedge clk);
      req <= 1'b1;
      req_lvl <= l;
      #1;
      chk("grant", {15'h0, grant}, {15'h0, e});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Generous ceiling; the sequence needs well under 400 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rreg(3'(i), rv);
         chk("reset read", rv, 16'h0000);
      end
      wreg(ADR_CPU_STATUS, 16'hffff);
      chk("level", {12'h0, prio}, 16'h0007);
      rreg(ADR_CPU_STATUS, rv);
      chk("status", rv, 16'h00e0);
      @(posedge clk);
      #1;
      chk("rdata idle", rdata, 16'h0000);
      for (int i = 0; i < 8; i++)
         gchk(3'(i), 1'b0);
      wreg(ADR_CPU_STATUS, 16'h0040);
      gchk(3'h3, 1'b1);
      gchk(3'h2, 1'b0);
      core.load(4'ha);
      #1;
      chk("level", {12'h0, prio}, 16'h000a);
      gchk(3'h7, 1'b0);
      rreg(ADR_CORE_CTRL, rv);
      chk("core ctrl", rv, 16'h0008);
      wreg(ADR_CORE_CTRL, 16'hffff);
      chk("level", {12'h0, prio}, 16'h000a);
      wreg(ADR_CORE_CTRL, 16'h0000);
      chk("level", {12'h0, prio}, 16'h0002);
      wreg(ADR_CORE_CTRL, 16'h0008);
      rreg(ADR_CORE_CTRL, rv);
      chk("core ctrl", rv, 16'h0000);
      wreg(ADR_INT_CTRL, 16'h8000);
      chk("nest", {15'h0, nest}, 16'h0001);
      rreg(ADR_INT_CTRL, rv);
      chk("int ctrl", rv, 16'h8000);
      wreg(ADR_CPU_STATUS, 16'h00e0);
      chk("level", {12'h0, prio}, 16'h0002);
      wreg(ADR_INT_CTRL, 16'h7fff);
      chk("nest", {15'h0, nest}, 16'h0000);
      rreg(ADR_INT_CTRL, rv);
      chk("int ctrl", rv, 16'h001e);
      wreg(ADR_INT_CTRL, 16'h0000);
      wreg(ADR_CPU_STATUS, 16'h0060);
      chk("level", {12'h0, prio}, 16'h0003);
      // Core load and software write land on the same edge
      fork
         wreg(ADR_CPU_STATUS, 16'h0020);
         core.load(4'h9);
      join
      chk("level", {12'h0, prio}, 16'h0009);
      wreg(ADR_TRAP_MASK, 16'h000f);
      for (int i = 0; i < 4; i++) begin
         core.fire(4'h8 >> i);
         #1;
         chk("flags", {12'h0, flags}, {12'h0, 4'h8 >> i});
         chk("irq", {15'h0, irq}, 16'h0001);
         rreg(ADR_INT_CTRL, rv);
         chk("int ctrl", rv, {11'h0, 4'h8 >> i, 1'b0});
         rreg(ADR_TRAP_EVENT, rv);
         chk("event", rv, {12'h0, 4'h8 >> i});
         wreg(ADR_TRAP_EVENT, 16'h000f);
         chk("irq", {15'h0, irq}, 16'h0000);
         wreg(ADR_INT_CTRL, 16'h0000);
         chk("flags", {12'h0, flags}, 16'h0000);
      end
      wreg(ADR_TRAP_MASK, 16'h0000);
      core.fire(4'hf);
      #1;
      chk("irq", {15'h0, irq}, 16'h0000);
      chk("flags", {12'h0, flags}, 16'h000f);
      fork
         wreg(ADR_INT_CTRL, 16'h0000);
         core.fire(4'h4);
      join
      #1;
      chk("flags", {12'h0, flags}, 16'h0004);
      wreg(ADR_TRAP_MASK, 16'h0001);
      @(posedge clk);
      #1;
      chk("irq", {15'h0, irq}, 16'h0001);
      wreg(ADR_TRAP_EVENT, 16'h0001);
      chk("irq", {15'h0, irq}, 16'h0000);
      // Mid-run reset with every kind of state set
      wreg(ADR_INT_CTRL, 16'h8000);
      core.fire(4'h3);
      core.load(4'hf);
      #1;
      chk("irq", {15'h0, irq}, 16'h0001);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("level", {12'h0, prio}, 16'h0000);
      chk("flags", {12'h0, flags}, 16'h0000);
      chk("nest", {15'h0, nest}, 16'h0000);
      chk("irq", {15'h0, irq}, 16'h0000);
      rreg(ADR_TRAP_EVENT, rv);
      chk("event", rv, 16'h0000);
      wrap_up();
   end
endmodule
